//--- vipu_params.svh
// Register map, field positions, reset values and vectors of the interrupt unit
`ifndef VIPU_PARAMS_SVH
`define VIPU_PARAMS_SVH
`define VIPU_OFS_ENABLE   8'h00
`define VIPU_OFS_ENPRIO2  8'h04
`define VIPU_OFS_PRIO     8'h08
`define VIPU_OFS_EXTCFG   8'h0C
`define VIPU_OFS_STATUS   8'h10
`define VIPU_OFS_VECTOR   8'h14
`define VIPU_RST_ENABLE   8'h00
`define VIPU_RST_ENPRIO2  8'h00
`define VIPU_RST_PRIO     8'h00
`define VIPU_RST_EXTCFG   2'h0
`define VIPU_RST_VECTOR   8'h00
`define VIPU_EN_GLOBAL    7
`define VIPU_EN_CONV      6
`define VIPU_EN_TMR2      5
`define VIPU_EN_UART      4
`define VIPU_EN_TMR1      3
`define VIPU_EN_EXT1      2
`define VIPU_EN_TMR0      1
`define VIPU_EN_EXT0      0
`define VIPU_E2_WDOG_PRI  7
`define VIPU_E2_TIC_PRI   6
`define VIPU_E2_PSM_PRI   5
`define VIPU_E2_SPI_PRI   4
`define VIPU_E2_WDOG_EN   3
`define VIPU_E2_TIC_EN    2
`define VIPU_E2_PSM_EN    1
`define VIPU_E2_SPI_EN    0
`define VIPU_PR_CONV      6
`define VIPU_PR_TMR2      5
`define VIPU_PR_UART      4
`define VIPU_PR_TMR1      3
`define VIPU_PR_EXT1      2
`define VIPU_PR_TMR0      1
`define VIPU_PR_EXT0      0
`define VIPU_VEC_PSM      8'h43
`define VIPU_VEC_WDOG     8'h5B
`define VIPU_VEC_EXT0     8'h03
`define VIPU_VEC_CONV     8'h33
`define VIPU_VEC_TMR0     8'h0B
`define VIPU_VEC_EXT1     8'h13
`define VIPU_VEC_TMR1     8'h1B
`define VIPU_VEC_SPI      8'h3B
`define VIPU_VEC_UART     8'h23
`define VIPU_VEC_TMR2     8'h2B
`define VIPU_VEC_TIC      8'h53
`define VIPU_NUM_SRC      11
`endif

//--- vipu_pkg.sv
// Types shared by the interrupt unit files
package vipu_pkg;
  typedef logic [3:0] src_idx_t;
  typedef logic [7:0] vector_t;
  typedef enum logic [0:0] {
    LEVEL_LOW,
    LEVEL_HIGH
  } level_e;
endpackage : vipu_pkg

//--- ext_request_capture.sv
// External request flag: level follow or falling-edge latch with hardware clear
`timescale 1ns/1ps
`default_nettype none
module ext_request_capture (
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic pin_n,
  input  wire logic edge_sel,
  input  wire logic clear_req,
  output logic      flag_ff
);
  logic pin_prev_ff;
  logic nxt_pin_prev;
  logic nxt_flag;

  always_comb begin
    nxt_pin_prev = pin_n;
    if (!edge_sel) begin
      // Level mode tracks the pin, so it cannot be cleared by the unit
      nxt_flag = !pin_n;
    end else if (pin_prev_ff && !pin_n) begin
      // A new edge beats a clear in the same cycle
      nxt_flag = 1'b1;
    end else if (clear_req) begin
      nxt_flag = 1'b0;
    end else begin
      nxt_flag = flag_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_prev_ff <= 1'b1;
      flag_ff     <= 1'b0;
    end else begin
      pin_prev_ff <= nxt_pin_prev;
      flag_ff     <= nxt_flag;
    end
  end
endmodule : ext_request_capture
`default_nettype wire

//--- vectored_interrupt_priority_unit.sv
// Vectored two-level interrupt controller with classic Wishbone registers
// Summary of operation
// [R01] Supply monitor: vector 43h, rank 1
// [R02] Watchdog status: vector 5Bh, rank 2
// [R03] External request zero: vector 03h, rank 3
// [R04] Converter done pair: vector 33h, rank 4
// [R05] Timer zero overflow: vector 0Bh, rank 5
// [R06] External request one: vector 13h, rank 6
// [R07] Timer one overflow: vector 1Bh, rank 7
// [R08] SPI or two-wire done: vector 3Bh, rank 8
// [R09] UART receive or transmit: vector 23h, rank 9
// [R10] Timer two flags: vector 2Bh, rank 10
// [R11] Interval counter: vector 53h, rank 11
// [R12] Same level: smallest rank served first
// [R13] Global enable zero blocks every request
// [R14] Priority bit sets converter request level
// [R15] External zero type: level or edge
// [R16] External one type: level or edge
// [R17] Only higher level preempts running service
// [R18] Core returns; active level is restored
//
// Added by the designer: the Wishbone slave port and the address map.
`include "vipu_params.svh"
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_priority_unit #(
  parameter int NUM_SRC = `VIPU_NUM_SRC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        supply_monitor_irq_flag,
  input  wire logic        wdog_status_flag,
  input  wire logic        ext0_pin_n,
  input  wire logic        primary_conv_done,
  input  wire logic        aux_conv_done,
  input  wire logic        tmr0_overflow,
  input  wire logic        ext1_pin_n,
  input  wire logic        tmr1_overflow,
  input  wire logic        spi_done_flag,
  input  wire logic        twowire_done_flag,
  input  wire logic        rx_done_flag,
  input  wire logic        tx_done_flag,
  input  wire logic        tmr2_overflow,
  input  wire logic        tmr2_external_flag,
  input  wire logic        interval_irq_flag,
  input  wire logic        vector_taken,
  input  wire logic        return_from_irq_instr,
  output logic             irq_req_ff,
  output logic      [7:0]  irq_vector_ff,
  output logic             irq_level_ff
);
  localparam vipu_pkg::vector_t VEC_TABLE [NUM_SRC] = '{
    `VIPU_VEC_PSM,   // R01
    `VIPU_VEC_WDOG,  // R02
    `VIPU_VEC_EXT0,  // R03
    `VIPU_VEC_CONV,  // R04
    `VIPU_VEC_TMR0,  // R05
    `VIPU_VEC_EXT1,  // R06
    `VIPU_VEC_TMR1,  // R07
    `VIPU_VEC_SPI,   // R08
    `VIPU_VEC_UART,  // R09
    `VIPU_VEC_TMR2,  // R10
    `VIPU_VEC_TIC    // R11
  };
  localparam vipu_pkg::src_idx_t SRC_EXT0 = 4'h2;
  localparam vipu_pkg::src_idx_t SRC_EXT1 = 4'h5;

  logic [7:0]                irq_enable_ff, nxt_irq_enable;
  logic [7:0]                irq_enprio2_ff, nxt_irq_enprio2;
  logic [7:0]                irq_prio_ff, nxt_irq_prio;
  logic [1:0]                extcfg_ff, nxt_extcfg;
  logic [31:0]               nxt_dat;
  logic                      nxt_ack;
  logic                      in_lo_ff, nxt_in_lo;
  logic                      in_hi_ff, nxt_in_hi;
  vipu_pkg::src_idx_t        src_ff, nxt_src;
  logic                      nxt_irq_req;
  vipu_pkg::vector_t         nxt_vector;
  logic                      nxt_level;
  logic                      ext0_flag;
  logic                      ext1_flag;
  logic [NUM_SRC-1:0]        pending;
  logic [NUM_SRC-1:0]        enables;
  logic [NUM_SRC-1:0]        prio;
  logic [NUM_SRC-1:0]        en_pend;
  logic                      bus_req;
  logic                      take;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign take    = vector_taken && irq_req_ff;

  // Edge flags are cleared by the unit only when their own vector is taken
  ext_request_capture u_ext0 (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .pin_n     (ext0_pin_n),
    .edge_sel  (extcfg_ff[0]),                   // R15
    .clear_req (take && src_ff == SRC_EXT0),
    .flag_ff   (ext0_flag)
  );
  ext_request_capture u_ext1 (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .pin_n     (ext1_pin_n),
    .edge_sel  (extcfg_ff[1]),                   // R16
    .clear_req (take && src_ff == SRC_EXT1),
    .flag_ff   (ext1_flag)
  );

  always_comb begin
    pending = {interval_irq_flag,
               tmr2_overflow || tmr2_external_flag,           // R10
               rx_done_flag || tx_done_flag,                  // R09
               spi_done_flag || twowire_done_flag,            // R08
               tmr1_overflow, ext1_flag, tmr0_overflow,
               primary_conv_done || aux_conv_done,            // R04
               ext0_flag, wdog_status_flag, supply_monitor_irq_flag};
    enables = {irq_enprio2_ff[`VIPU_E2_TIC_EN], irq_enable_ff[`VIPU_EN_TMR2],
               irq_enable_ff[`VIPU_EN_UART], irq_enprio2_ff[`VIPU_E2_SPI_EN],
               irq_enable_ff[`VIPU_EN_TMR1], irq_enable_ff[`VIPU_EN_EXT1],
               irq_enable_ff[`VIPU_EN_TMR0], irq_enable_ff[`VIPU_EN_CONV],
               irq_enable_ff[`VIPU_EN_EXT0], irq_enprio2_ff[`VIPU_E2_WDOG_EN],
               irq_enprio2_ff[`VIPU_E2_PSM_EN]};
    prio    = {irq_enprio2_ff[`VIPU_E2_TIC_PRI], irq_prio_ff[`VIPU_PR_TMR2],
               irq_prio_ff[`VIPU_PR_UART], irq_enprio2_ff[`VIPU_E2_SPI_PRI],
               irq_prio_ff[`VIPU_PR_TMR1], irq_prio_ff[`VIPU_PR_EXT1],
               irq_prio_ff[`VIPU_PR_TMR0], irq_prio_ff[`VIPU_PR_CONV],                // R14
               irq_prio_ff[`VIPU_PR_EXT0], irq_enprio2_ff[`VIPU_E2_WDOG_PRI],
               irq_enprio2_ff[`VIPU_E2_PSM_PRI]};
    en_pend = pending & enables & {NUM_SRC{irq_enable_ff[`VIPU_EN_GLOBAL]}};    // R13
  end

  // Arbitration: high level first, then lowest rank; service state gates
  always_comb begin
    logic              found;
    vipu_pkg::level_e  lvl;
    found = 1'b0;
    lvl   = vipu_pkg::LEVEL_LOW;
    nxt_src = src_ff;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (en_pend[i] && prio[i] && !in_hi_ff) begin                             // R17
        found   = 1'b1;
        lvl     = vipu_pkg::LEVEL_HIGH;
        nxt_src = vipu_pkg::src_idx_t'(i);                                      // R12
      end
    end
    if (!found) begin
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        if (en_pend[i] && !prio[i] && !in_hi_ff && !in_lo_ff) begin             // R17
          found   = 1'b1;
          nxt_src = vipu_pkg::src_idx_t'(i);                                    // R12
        end
      end
    end
    // A taken request drops at once so it is not offered twice
    nxt_irq_req = found && !take;
    nxt_vector  = found ? VEC_TABLE[nxt_src] : irq_vector_ff;
    nxt_level   = found ? (lvl == vipu_pkg::LEVEL_HIGH) : irq_level_ff;
  end

  // Service state: nested at most one low and one high routine
  always_comb begin
    nxt_in_lo = in_lo_ff;
    nxt_in_hi = in_hi_ff;
    if (return_from_irq_instr) begin
      if (in_hi_ff) begin
        nxt_in_hi = 1'b0;                                                       // R18
      end else begin
        nxt_in_lo = 1'b0;                                                       // R18
      end
    end
    if (take) begin
      if (irq_level_ff) begin
        nxt_in_hi = 1'b1;
      end else begin
        nxt_in_lo = 1'b1;
      end
    end
  end

  // Register file: one aligned word per register, byte lane 0 only
  always_comb begin
    nxt_irq_enable  = irq_enable_ff;
    nxt_irq_enprio2 = irq_enprio2_ff;
    nxt_irq_prio    = irq_prio_ff;
    nxt_extcfg      = extcfg_ff;
    nxt_ack         = bus_req;
    nxt_dat         = 32'h0000_0000;
    if (bus_req && wb_we_i && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        `VIPU_OFS_ENABLE:  nxt_irq_enable  = wb_dat_i[7:0];
        `VIPU_OFS_ENPRIO2: nxt_irq_enprio2 = wb_dat_i[7:0];
        `VIPU_OFS_PRIO:    nxt_irq_prio    = {1'b0, wb_dat_i[6:0]};
        `VIPU_OFS_EXTCFG:  nxt_extcfg      = wb_dat_i[1:0];
        default:           nxt_irq_enable  = irq_enable_ff;
      endcase
    end
    if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        `VIPU_OFS_ENABLE:  nxt_dat[7:0] = irq_enable_ff;
        `VIPU_OFS_ENPRIO2: nxt_dat[7:0] = irq_enprio2_ff;
        `VIPU_OFS_PRIO:    nxt_dat[7:0] = irq_prio_ff;
        `VIPU_OFS_EXTCFG: nxt_dat[1:0] = extcfg_ff;
        `VIPU_OFS_STATUS: nxt_dat[5:0] = {ext1_flag, ext0_flag, irq_level_ff,
                                          irq_req_ff, in_hi_ff, in_lo_ff};
        `VIPU_OFS_VECTOR: nxt_dat[7:0] = irq_vector_ff;
        default:          nxt_dat      = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irq_enable_ff  <= `VIPU_RST_ENABLE;
      irq_enprio2_ff <= `VIPU_RST_ENPRIO2;
      irq_prio_ff    <= `VIPU_RST_PRIO;
      extcfg_ff     <= `VIPU_RST_EXTCFG;
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h0000_0000;
      in_lo_ff      <= 1'b0;
      in_hi_ff      <= 1'b0;
      src_ff        <= 4'h0;
      irq_req_ff    <= 1'b0;
      irq_vector_ff <= `VIPU_RST_VECTOR;
      irq_level_ff  <= 1'b0;
    end else begin
      irq_enable_ff  <= nxt_irq_enable;
      irq_enprio2_ff <= nxt_irq_enprio2;
      irq_prio_ff    <= nxt_irq_prio;
      extcfg_ff     <= nxt_extcfg;
      wb_ack_o      <= nxt_ack;
      wb_dat_o      <= nxt_dat;
      in_lo_ff      <= nxt_in_lo;
      in_hi_ff      <= nxt_in_hi;
      src_ff        <= nxt_src;
      irq_req_ff    <= nxt_irq_req;
      irq_vector_ff <= nxt_vector;
      irq_level_ff  <= nxt_level;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Helpers for the checks below
  logic [NUM_SRC-1:0] hi_cand;
  logic [NUM_SRC-1:0] lo_cand;
  assign hi_cand = en_pend & prio;
  assign lo_cand = en_pend & ~prio;

  sequence s_offer;
    irq_req_ff && vector_taken;
  endsequence
  sequence s_entered_low;
    ##1 in_lo_ff && !irq_req_ff;
  endsequence

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_rank
      localparam logic [NUM_SRC-1:0] ABOVE = NUM_SRC'((1 << g) - 1);
      a_rank_vector: assert property (                                          // R12
        (hi_cand[g] && !(|(hi_cand & ABOVE)) && !in_hi_ff && !vector_taken)
          |=> irq_req_ff && irq_vector_ff == VEC_TABLE[g] && irq_level_ff)
        else $error("highest ranked high-level source not offered");
      a_low_rank_vector: assert property (                                      // R12
        (lo_cand[g] && hi_cand == '0 && !(|(lo_cand & ABOVE)) && !in_hi_ff && !in_lo_ff
         && !vector_taken) |=> irq_req_ff && irq_vector_ff == VEC_TABLE[g])
        else $error("highest ranked low-level source not offered");
    end
  endgenerate

  a_global_gate: assert property (                                              // R13
    !irq_enable_ff[`VIPU_EN_GLOBAL] |=> !irq_req_ff)
    else $error("request offered while globally disabled");

  a_conv_level: assert property (                                               // R14
    (en_pend[3] && (hi_cand & 11'h007) == 11'h000 && irq_prio_ff[`VIPU_PR_CONV]
     && in_lo_ff && !in_hi_ff && !vector_taken) |=> irq_req_ff && irq_level_ff
                           && irq_vector_ff == `VIPU_VEC_CONV)
    else $error("converter request not raised to high level");

  a_ext0_edge: assert property (                                                // R15
    (extcfg_ff[0] && $past(ext0_pin_n) && !ext0_pin_n) |=> ext0_flag)
    else $error("falling edge on request zero not latched");

  a_ext1_level: assert property (                                               // R16
    (!extcfg_ff[1]) |=> ext1_flag == !$past(ext1_pin_n))
    else $error("request one level mode does not follow pin");

  a_no_preempt: assert property (                                               // R17
    in_hi_ff |=> !irq_req_ff)
    else $error("request offered during high-level service");

  a_take_low: assert property (                                                 // R17
    s_offer and (!irq_level_ff && !in_hi_ff && !return_from_irq_instr)
      |-> s_entered_low)
    else $error("low-level take did not block further low requests");

  a_return_hi: assert property (                                                // R18
    (return_from_irq_instr && in_hi_ff && !vector_taken) |=> !in_hi_ff
                                                            && in_lo_ff == $past(in_lo_ff))
    else $error("return did not restore the previous service level");

  a_bus_ack: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus access not acknowledged in one cycle");
endmodule : vectored_interrupt_priority_unit
`default_nettype wire

//--- vipu_core_model.sv
// Processor core stand-in: takes offered vectors and returns on command
`timescale 1ns/1ps
`default_nettype none
module vipu_core_model (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       irq_req_ff,
  input  wire logic [7:0] irq_vector_ff,
  input  wire logic       irq_level_ff,
  input  wire logic [3:0] take_delay,
  input  wire logic       ret_cmd,
  output logic            vector_taken,
  output logic            return_from_irq_instr,
  output logic [7:0]      last_vec,
  output logic            last_lvl,
  output logic [7:0]      n_taken
);
  logic [3:0] wait_ff;

  // A slow take lets a late, better source replace the offered vector, so
  // the vector is recorded at the edge where the unit accepts the take
  always_ff @(posedge sys_clk) begin
    vector_taken          <= 1'b0;
    return_from_irq_instr <= ret_cmd & ~reset;
    if (reset) begin
      wait_ff  <= 4'h0;
      n_taken  <= 8'h00;
      last_vec <= 8'h00;
      last_lvl <= 1'b0;
    end else begin
      if (vector_taken && irq_req_ff) begin
        last_vec <= irq_vector_ff;
        last_lvl <= irq_level_ff;
        n_taken  <= n_taken + 8'h01;
      end
      if (vector_taken || !irq_req_ff) begin
        wait_ff <= 4'h0;
      end else if (wait_ff == take_delay) begin
        vector_taken <= 1'b1;
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule : vipu_core_model
`default_nettype wire

//--- tb_vectored_interrupt_priority_unit.sv
// Self-checking bench for the vectored interrupt priority unit
`include "vipu_params.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_vectored_interrupt_priority_unit;
  logic        sys_clk;
  logic        reset;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [14:0] src;
  logic        vector_taken;
  logic        return_from_irq_instr;
  logic        irq_req_ff;
  logic [7:0]  irq_vector_ff;
  logic        irq_level_ff;
  logic [3:0]  take_delay;
  logic        ret_cmd;
  logic [7:0]  last_vec;
  logic        last_lvl;
  logic [7:0]  n_taken;
  logic [7:0]  takes;
  int          n_mismatch;
  int          check_count;
  int          cycles;

  vectored_interrupt_priority_unit u_dut (
    .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .supply_monitor_irq_flag(src[0]),
    .wdog_status_flag(src[1]), .ext0_pin_n(~src[2]), .primary_conv_done(src[3]),
    .aux_conv_done(src[4]), .tmr0_overflow(src[5]), .ext1_pin_n(~src[6]),
    .tmr1_overflow(src[7]), .spi_done_flag(src[8]), .twowire_done_flag(src[9]),
    .rx_done_flag(src[10]), .tx_done_flag(src[11]), .tmr2_overflow(src[12]),
    .tmr2_external_flag(src[13]), .interval_irq_flag(src[14]),
    .vector_taken(vector_taken), .return_from_irq_instr(return_from_irq_instr),
    .irq_req_ff(irq_req_ff), .irq_vector_ff(irq_vector_ff), .irq_level_ff(irq_level_ff));

  vipu_core_model u_core (
    .sys_clk(sys_clk), .reset(reset), .irq_req_ff(irq_req_ff),
    .irq_vector_ff(irq_vector_ff), .irq_level_ff(irq_level_ff), .take_delay(take_delay),
    .ret_cmd(ret_cmd), .vector_taken(vector_taken),
    .return_from_irq_instr(return_from_irq_instr), .last_vec(last_vec),
    .last_lvl(last_lvl), .n_taken(n_taken));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
          input logic [3:0] sel, output logic [31:0] rd);
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= dat;
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] d;
    wb(1'b1, adr, dat, sel, d);
  endtask : wr

  task rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0, 4'hF, d);
    check(d, exp);
  endtask : rd_chk

  // Expects exactly one more take than so far, with the given vector and level
  task wait_take(input logic [7:0] vec, input logic lvl);
    int t;
    t = 0;
    while (n_taken === takes && t < 60) begin
      @(posedge sys_clk);
      t++;
    end
    takes = takes + 8'h01;
    check(32'({last_lvl, n_taken, last_vec}), 32'({lvl, takes, vec}));
  endtask : wait_take

  task no_req;
    repeat (6) @(posedge sys_clk);
    check(32'({irq_req_ff, n_taken}), 32'({1'b0, takes}));
  endtask : no_req

  task retn;
    @(posedge sys_clk);
    ret_cmd <= 1'b1;
    @(posedge sys_clk);
    ret_cmd <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : retn

  task test_regs;
    for (int i = 0; i < 6; i++) rd_chk(8'(4 * i), 32'h0);
    wr(`VIPU_OFS_ENABLE, 32'hA5, 4'h1);
    rd_chk(`VIPU_OFS_ENABLE, 32'hA5);
    wr(`VIPU_OFS_ENPRIO2, 32'h5A, 4'h1);
    rd_chk(`VIPU_OFS_ENPRIO2, 32'h5A);
    wr(`VIPU_OFS_PRIO, 32'hFF, 4'h1);
    rd_chk(`VIPU_OFS_PRIO, 32'h7F);
    wr(`VIPU_OFS_PRIO, 32'h00, 4'hE);
    rd_chk(`VIPU_OFS_PRIO, 32'h7F);
    wr(8'h18, 32'hFF, 4'h1);
    rd_chk(8'h18, 32'h0);
    wr(`VIPU_OFS_PRIO, 32'h00, 4'h1);
    wr(`VIPU_OFS_ENPRIO2, 32'h0F, 4'h1);
  endtask : test_regs

  task test_sweep;
    int a[11] = '{0, 1, 2, 3, 5, 6, 7, 8, 10, 12, 14};
    int b[11] = '{0, 1, 2, 4, 5, 6, 7, 9, 11, 13, 14};
    logic [7:0] v[11] = '{8'h43, 8'h5B, 8'h03, 8'h33, 8'h0B, 8'h13, 8'h1B, 8'h3B, 8'h23,
                          8'h2B, 8'h53};
    wr(`VIPU_OFS_ENABLE, 32'hFF, 4'h1);
    // Second pass uses the other member of every shared request
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 11; i++) src[p ? b[i] : a[i]] <= 1'b1;
      for (int i = 0; i < 11; i++) begin
        take_delay <= 4'(i % 3);
        wait_take(v[i], 1'b0);
        src[p ? b[i] : a[i]] <= 1'b0;
        retn();
      end
    end
  endtask : test_sweep

  task test_global;
    wr(`VIPU_OFS_ENABLE, 32'h7F, 4'h1);
    src[5] <= 1'b1;
    no_req();
    wr(`VIPU_OFS_ENABLE, 32'hFF, 4'h1);
    wait_take(8'h0B, 1'b0);
    src[5] <= 1'b0;
    retn();
  endtask : test_global

  task test_preempt;
    wr(`VIPU_OFS_PRIO, 32'h40, 4'h1);
    src[5] <= 1'b1;
    wait_take(8'h0B, 1'b0);
    src[3] <= 1'b1;
    wait_take(8'h33, 1'b1);
    // Both service levels active, level bit still high, nothing offered
    rd_chk(`VIPU_OFS_STATUS, 32'h0B);
    rd_chk(`VIPU_OFS_VECTOR, 32'h33);
    src[0] <= 1'b1;
    no_req();
    src[3] <= 1'b0;
    retn();
    no_req();
    src[5] <= 1'b0;
    retn();
    wait_take(8'h43, 1'b0);
    src[3] <= 1'b1;
    retn();
    wait_take(8'h33, 1'b1);
    src[3] <= 1'b0;
    src[0] <= 1'b0;
    retn();
    wr(`VIPU_OFS_PRIO, 32'h00, 4'h1);
  endtask : test_preempt

  // Pins held low: edge mode offers once, level mode offers again
  task test_ext;
    wr(`VIPU_OFS_EXTCFG, 32'h03, 4'h1);
    src[2] <= 1'b1;
    wait_take(8'h03, 1'b0);
    retn();
    no_req();
    src[6] <= 1'b1;
    wait_take(8'h13, 1'b0);
    retn();
    no_req();
    wr(`VIPU_OFS_EXTCFG, 32'h00, 4'h1);
    wait_take(8'h03, 1'b0);
    src[2] <= 1'b0;
    retn();
    wait_take(8'h13, 1'b0);
    src[6] <= 1'b0;
    retn();
  endtask : test_ext

  task test_done;
    $display("checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Whole run needs about 400 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    reset = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, ret_cmd} = 4'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    src = 15'h0;
    take_delay = 4'h0;
    takes = 8'h00;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    test_regs();
    $display("register test ended");
    test_sweep();
    $display("vector and rank test ended");
    test_global();
    $display("global enable test ended");
    test_preempt();
    $display("preemption test ended");
    test_ext();
    $display("external request test ended");
    test_done();
  end
endmodule : tb_vectored_interrupt_priority_unit
`default_nettype wire
